// ===== rtl/lsfs_supervisor.sv
// Purpose: Supervisory control of boost converter and three LED strings.
// Assumes: All analog indications arrive as asynchronous digital levels.
// Notes:   Analog regulation is outside; this block only gates and sequences.
`timescale 1ns/100ps

// Functional notes
// - Enable high turns on converter and all sources without a latched fault; low keeps them off.
// - Sources follow the enable level so brightness tracks PWM duty.
// - Supplies ramp gradually on enable, progressing even with tiny PWM duty.
// - Open and short monitoring starts only after startup completes.
// - A faulty string is disabled alone; others keep running.
// - String faults stay latched until shutdown, which clears them all.
// - Enabled string below short threshold for debounce time is shorted.
// - Short debounce at most nine microseconds and longer than open debounce.
// - Right after enable rises, outputs tied to rail or ground are disabled.
// - Open declared when rail at open-check level and source below threshold.
// - Open debounce at most 4.8 microseconds.
// - No open declared if coil current limit hit before open-check level.
// - Rail at clamp beyond about 70 ms shuts the converter down.
// - Coil charging ends each cycle once current limit is reached.
// - Overtemperature stops converter; restarts below threshold minus hysteresis.
// - Supply at or below undervoltage level holds shutdown regardless of enable.
module lsfs_supervisor
  import lsfs_pkg::*;
#(
  parameter int OPEN_CYC    = OPEN_DEB_CYC,
  parameter int SHORT_CYC   = SHORT_DEB_CYC,
  parameter int OV_CYC      = OV_TIMEOUT_CYC,
  parameter int REARM_CYC   = REARM_LOW_CYC,
  parameter int RAMP_CYC    = RAMP_STEP_CYC
)(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // Host enable, may carry PWM
  input  wire logic                   enable_in,
  // Analog comparator indications
  input  wire logic                   supply_input_uvlo,
  input  wire logic                   overtemp_above_thr,
  input  wire logic                   overtemp_below_hyst,
  input  wire logic                   rail_at_clamp,
  input  wire logic                   rail_at_open_check,
  input  wire logic                   coil_at_limit,
  input  wire logic [NUM_STRINGS-1:0] string_below_short,
  input  wire logic [NUM_STRINGS-1:0] string_below_open,
  input  wire logic [NUM_STRINGS-1:0] string_tied,
  // Converter and source control
  output logic                        boost_en_q,
  output logic                        coil_charge_q,
  output logic [RAMP_W-1:0]           ramp_level_q,
  output logic [NUM_STRINGS-1:0]      source_en_q,
  output logic [NUM_STRINGS-1:0]      string_fault
);

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic rst_m_q, rst_q_b;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_m_q <= 1'b0;
      rst_q_b <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_q_b <= rst_m_q;
    end
  end

  localparam int SYNC_W = 7 + 3 * NUM_STRINGS;
  logic [SYNC_W-1:0] async_in, sync1_q, sync2_q;

  assign async_in = {string_tied, string_below_open, string_below_short, coil_at_limit,
                     rail_at_open_check, rail_at_clamp, overtemp_below_hyst,
                     overtemp_above_thr, supply_input_uvlo, enable_in};

  always_ff @(posedge core_clk or negedge rst_q_b)
  begin
    if (!rst_q_b)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  logic                   en_s, uvlo_s, ot_hi_s, ot_lo_s, clamp_s, openlvl_s, ilim_s;
  logic [NUM_STRINGS-1:0] short_s, open_s, tied_s;

  assign {tied_s, open_s, short_s, ilim_s, openlvl_s, clamp_s, ot_lo_s, ot_hi_s, uvlo_s,
          en_s} = sync2_q;

  // ****************************************
  // Sequencing state
  // ****************************************
  lsfs_state_t      state_q, state_d;
  logic [CNT_W-1:0] ov_cnt_q, ov_cnt_d;
  logic [CNT_W-1:0] low_cnt_q, low_cnt_d;
  logic [CNT_W-1:0] step_cnt_q, step_cnt_d;
  logic [RAMP_W-1:0] ramp_d;
  logic             ot_stop_q, ot_stop_d;
  logic             en_prev_q, en_prev_d;
  logic             ilim_seen_q, ilim_seen_d;
  logic             boost_en_d, coil_charge_d;
  logic [NUM_STRINGS-1:0] source_en_d;
  logic             shutdown, monitor_en, tie_pulse;

  // Shutdown is both the state and the overvoltage lock, so faults clear whenever either applies.
  assign shutdown   = (state_q == LSFS_SHUTDOWN) || (state_q == LSFS_OVLOCK);
  assign monitor_en = (state_q == LSFS_RUN);
  assign tie_pulse  = en_s && !en_prev_q;

  always_comb
  begin
    state_d     = state_q;
    ov_cnt_d    = '0;
    low_cnt_d   = '0;
    step_cnt_d  = step_cnt_q;
    ramp_d      = ramp_level_q;
    ot_stop_d   = ot_stop_q;
    en_prev_d   = en_s;
    ilim_seen_d = ilim_seen_q;
    if (ot_hi_s)
    begin
      ot_stop_d = 1'b1;
    end
    else if (ot_lo_s)
    begin
      ot_stop_d = 1'b0;
    end
    if (!en_s)
    begin
      low_cnt_d = (low_cnt_q == CNT_W'(REARM_CYC)) ? low_cnt_q : low_cnt_q + 1'b1;
    end
    case (state_q)
      LSFS_SHUTDOWN:
      begin
        ramp_d      = '0;
        step_cnt_d  = '0;
        ilim_seen_d = 1'b0;
        if (en_s && !uvlo_s)
        begin
          state_d = LSFS_RAMP;
        end
      end
      LSFS_RAMP:
      begin
        // The ramp holds its level while enable is low, so short pulses still finish it.
        if (en_s)
        begin
          step_cnt_d = step_cnt_q + 1'b1;
          if (step_cnt_q >= CNT_W'(RAMP_CYC - 1) && ramp_level_q != RAMP_FULL)
          begin
            step_cnt_d = '0;
            ramp_d     = ramp_level_q + 1'b1;
          end
        end
        if (ramp_level_q == RAMP_FULL)
        begin
          state_d = LSFS_RUN;
        end
      end
      LSFS_RUN:
      begin
        if (clamp_s && !ot_stop_q)
        begin
          ov_cnt_d = ov_cnt_q + 1'b1;
          if (ov_cnt_q >= CNT_W'(OV_CYC - 1))
          begin
            state_d = LSFS_OVLOCK;
          end
        end
        if (ilim_s && !openlvl_s)
        begin
          ilim_seen_d = 1'b1;
        end
        if (openlvl_s && !ilim_s)
        begin
          ilim_seen_d = 1'b0;
        end
      end
      LSFS_OVLOCK:
      begin
        if (low_cnt_q == CNT_W'(REARM_CYC))
        begin
          state_d = LSFS_SHUTDOWN;
        end
      end
      default:
      begin
        state_d = LSFS_SHUTDOWN;
      end
    endcase
    // Held-low enable long enough also counts as shutdown from any running state.
    if ((state_q == LSFS_RAMP || state_q == LSFS_RUN) &&
        (uvlo_s || low_cnt_q == CNT_W'(REARM_CYC)))
    begin
      state_d = LSFS_SHUTDOWN;
    end
  end

  always_comb
  begin
    boost_en_d    = en_s && !uvlo_s && !ot_stop_d &&
                    (state_d == LSFS_RAMP || state_d == LSFS_RUN);
    coil_charge_d = boost_en_d && !ilim_s;
    source_en_d   = {NUM_STRINGS{boost_en_d}} & ~string_fault;
  end

  always_ff @(posedge core_clk or negedge rst_q_b)
  begin
    if (!rst_q_b)
    begin
      state_q       <= LSFS_SHUTDOWN;
      ov_cnt_q      <= '0;
      low_cnt_q     <= '0;
      step_cnt_q    <= '0;
      ramp_level_q  <= '0;
      ot_stop_q     <= 1'b0;
      en_prev_q     <= 1'b0;
      ilim_seen_q   <= 1'b0;
      boost_en_q    <= 1'b0;
      coil_charge_q <= 1'b0;
      source_en_q   <= '0;
    end
    else
    begin
      state_q       <= state_d;
      ov_cnt_q      <= ov_cnt_d;
      low_cnt_q     <= low_cnt_d;
      step_cnt_q    <= step_cnt_d;
      ramp_level_q  <= ramp_d;
      ot_stop_q     <= ot_stop_d;
      en_prev_q     <= en_prev_d;
      ilim_seen_q   <= ilim_seen_d;
      boost_en_q    <= boost_en_d;
      coil_charge_q <= coil_charge_d;
      source_en_q   <= source_en_d;
    end
  end

  // ****************************************
  // Per-string monitors
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_STRINGS; gi++)
    begin : g_str
      lsfs_string_mon #(
        .OPEN_CYC  (OPEN_CYC),
        .SHORT_CYC (SHORT_CYC)
      ) u_mon (
        .core_clk      (core_clk),
        .rst_q_b       (rst_q_b),
        .monitor_en    (monitor_en),
        .shutdown      (shutdown),
        .src_on        (source_en_q[gi]),
        .open_check_ok (openlvl_s && !ilim_seen_q),
        .tie_detect    (tie_pulse && tied_s[gi]),
        .below_short   (short_s[gi]),
        .below_open    (open_s[gi]),
        .fault_q       (string_fault[gi])
      );
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  sequence s_ramp_done;
    state_q == LSFS_RAMP ##1 state_q == LSFS_RUN;
  endsequence

  chk_enable_off: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    !en_s |=> !boost_en_q && source_en_q == '0)
    else $error("converter on while enable low");

  chk_fault_source: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    (string_fault[0] |=> !source_en_q[0]))
    else $error("faulty string still driven");

  chk_uvlo_hold: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    uvlo_s |=> state_q == LSFS_SHUTDOWN || state_q == LSFS_OVLOCK)
    else $error("left shutdown under undervoltage");

  chk_monitor_late: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    s_ramp_done |-> ramp_level_q == RAMP_FULL)
    else $error("monitoring began before ramp finished");

  chk_coil_limit: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    ilim_s |=> !coil_charge_q)
    else $error("coil charging past current limit");

  chk_ot_stop: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    ot_hi_s |=> !boost_en_q)
    else $error("converter ran over temperature");

  chk_ov_lock: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    state_q == LSFS_OVLOCK |-> !boost_en_q)
    else $error("converter on after overvoltage timeout");

  chk_ramp_mono: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    state_q == LSFS_RAMP && $past(state_q) == LSFS_RAMP |->
      ramp_level_q >= $past(ramp_level_q))
    else $error("ramp level fell during startup");

endmodule : lsfs_supervisor

// ===== rtl/lsfs_pkg.sv
// Purpose: Shared constants for the LED string fault supervisor.
// Assumes: 50 MHz core clock.
// Notes:   Times are kept in their printed unit; cycle counts derive from them.
package lsfs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ            = 50;
  localparam int OPEN_DEB_NS        = 4800;
  localparam int SHORT_DEB_NS       = 9000;
  localparam int OV_TIMEOUT_MS      = 70;
  localparam int REARM_LOW_US       = 1000;
  localparam int RAMP_STEP_US       = 10;
  // Longest times round down.
  localparam int OPEN_DEB_CYC       = (OPEN_DEB_NS * CLK_MHZ) / 1000;
  localparam int SHORT_DEB_CYC      = (SHORT_DEB_NS * CLK_MHZ) / 1000;
  localparam int OV_TIMEOUT_CYC     = OV_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int REARM_LOW_CYC      = REARM_LOW_US * CLK_MHZ;
  localparam int RAMP_STEP_CYC      = RAMP_STEP_US * CLK_MHZ;

  // ****************************************
  // Structure
  // ****************************************
  localparam int NUM_STRINGS        = 3;
  localparam int RAMP_W             = 8;
  localparam logic [7:0] RAMP_FULL  = 8'hff;
  localparam int CNT_W              = 32;

  // ****************************************
  // Supervisor states
  // ****************************************
  typedef enum logic [1:0] {
    LSFS_SHUTDOWN = 2'b00,
    LSFS_RAMP     = 2'b01,
    LSFS_RUN      = 2'b11,
    LSFS_OVLOCK   = 2'b10
  } lsfs_state_t;

endpackage : lsfs_pkg

// ===== rtl/lsfs_string_mon.sv
// Purpose: Per-string fault debounce and latch.
// Assumes: Inputs already synchronised to core_clk.
// Notes:   Fault clears only in shutdown.
`timescale 1ns/100ps
module lsfs_string_mon
  import lsfs_pkg::*;
#(
  parameter int OPEN_CYC  = OPEN_DEB_CYC,
  parameter int SHORT_CYC = SHORT_DEB_CYC
)(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_q_b,
  // Control
  input  wire logic monitor_en,
  input  wire logic shutdown,
  input  wire logic src_on,
  input  wire logic open_check_ok,
  input  wire logic tie_detect,
  // Comparators
  input  wire logic below_short,
  input  wire logic below_open,
  // Result
  output logic      fault_q
);

  logic [CNT_W-1:0] short_cnt_q, short_cnt_d;
  logic [CNT_W-1:0] open_cnt_q,  open_cnt_d;
  logic             fault_d;

  always_comb
  begin
    short_cnt_d = '0;
    open_cnt_d  = '0;
    fault_d     = fault_q;
    if (monitor_en && src_on && !fault_q && below_short)
    begin
      short_cnt_d = short_cnt_q + 1'b1;
    end
    if (monitor_en && src_on && !fault_q && open_check_ok && below_open)
    begin
      open_cnt_d = open_cnt_q + 1'b1;
    end
    if (short_cnt_q >= CNT_W'(SHORT_CYC - 1) && short_cnt_d != '0)
    begin
      fault_d = 1'b1;
    end
    if (open_cnt_q >= CNT_W'(OPEN_CYC - 1) && open_cnt_d != '0)
    begin
      fault_d = 1'b1;
    end
    if (shutdown)
    begin
      fault_d     = 1'b0;
      short_cnt_d = '0;
      open_cnt_d  = '0;
    end
    // The tie check follows the clear, because the first enable edge still arrives in shutdown.
    if (tie_detect)
    begin
      fault_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_q_b)
  begin
    if (!rst_q_b)
    begin
      short_cnt_q <= '0;
      open_cnt_q  <= '0;
      fault_q     <= 1'b0;
    end
    else
    begin
      short_cnt_q <= short_cnt_d;
      open_cnt_q  <= open_cnt_d;
      fault_q     <= fault_d;
    end
  end

  chk_fault_latched: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    fault_q && !shutdown |=> fault_q)
    else $error("string fault dropped outside shutdown");

  chk_open_gated: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    !open_check_ok |=> open_cnt_q == '0)
    else $error("open debounce ran without open-check level");

  chk_short_bound: assert property (@(posedge core_clk) disable iff (!rst_q_b)
    short_cnt_q <= CNT_W'(SHORT_CYC))
    else $error("short debounce exceeded its interval");

endmodule : lsfs_string_mon

// ===== dv/lsfs_host_enable.sv
// Purpose: Host model driving the enable pin, steady or as PWM.
// Assumes: Commands change off the falling edge of core_clk.
// Notes:   The pin has a pull-down, so an idle host reads low.
`timescale 1ns/100ps
module lsfs_host_enable
(
  // Clock
  input  wire logic        core_clk,
  // Commands from the bench
  input  wire logic        level_req,
  input  wire logic        pwm_mode,
  input  wire logic [15:0] high_cyc,
  input  wire logic [15:0] period_cyc,
  // Pin
  output logic             enable_in
);
  logic [15:0] phase_q;

  initial
  begin
    enable_in = 1'b0;
    phase_q   = 16'h0000;
  end

  // ****************************************
  // Pin driver
  // ****************************************
  // A long steady low is how the host re-arms after an overvoltage stop.
  always @(negedge core_clk)
  begin
    phase_q   <= (phase_q + 16'h0001 >= period_cyc) ? 16'h0000 : phase_q + 16'h0001;
    enable_in <= pwm_mode ? (phase_q < high_cyc) : level_req;
  end
endmodule : lsfs_host_enable

// ===== dv/lsfs_supervisor_bench.sv
// Purpose: Self-checking bench for the LED string fault supervisor.
// Assumes: Short counts are used so the run stays brief.
// Notes:   Inputs change on the falling edge, outputs are read there too.
`timescale 1ns/100ps
module lsfs_supervisor_bench;
  localparam int OPEN_T  = 4;
  localparam int SHORT_T = 8;
  localparam int OV_T    = 200;
  localparam int REARM_T = 50;
  localparam int RAMP_T  = 2;

  logic        core_clk, rst_b, level_req, pwm_mode, enable_in;
  logic [15:0] high_cyc, period_cyc;
  logic        uvlo, ot_hi, ot_lo, clamp, open_chk, coil_lim;
  logic [2:0]  below_short, below_open, tied, src, fault;
  logic        boost, coil;
  logic [7:0]  ramp;
  int          bad_count, checked;

  // ****************************************
  // Clock, reset and instances
  // ****************************************
  initial
  begin
    core_clk = 1'b0; rst_b = 1'b0; level_req = 1'b0; pwm_mode = 1'b0;
    high_cyc = 16'h0001; period_cyc = 16'h000a;
    uvlo = 1'b0; ot_hi = 1'b0; ot_lo = 1'b1; clamp = 1'b0; open_chk = 1'b0;
    coil_lim = 1'b0; below_short = 3'h0; below_open = 3'h0; tied = 3'h0;
    bad_count = 0; checked = 0;
  end
  always #10 core_clk = ~core_clk;

  lsfs_host_enable host (.core_clk(core_clk), .level_req(level_req), .pwm_mode(pwm_mode),
    .high_cyc(high_cyc), .period_cyc(period_cyc), .enable_in(enable_in));

  lsfs_supervisor #(.OPEN_CYC(OPEN_T), .SHORT_CYC(SHORT_T), .OV_CYC(OV_T),
    .REARM_CYC(REARM_T), .RAMP_CYC(RAMP_T)) uut (.core_clk(core_clk), .rst_b(rst_b),
    .enable_in(enable_in), .supply_input_uvlo(uvlo), .overtemp_above_thr(ot_hi),
    .overtemp_below_hyst(ot_lo), .rail_at_clamp(clamp), .rail_at_open_check(open_chk),
    .coil_at_limit(coil_lim), .string_below_short(below_short),
    .string_below_open(below_open), .string_tied(tied), .boost_en_q(boost),
    .coil_charge_q(coil), .ramp_level_q(ramp), .source_en_q(src), .string_fault(fault));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_ramp();
    for (int i = 0; i < 256 * RAMP_T * 12 && ramp !== lsfs_pkg::RAMP_FULL; i++) step(1);
    check("ramp", ramp, lsfs_pkg::RAMP_FULL);
  endtask : wait_ramp

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_enable_uvlo();
    step(10);
    check("boost off", {7'h0, boost}, 8'h00);
    uvlo = 1'b1; level_req = 1'b1; step(20);
    check("boost uvlo", {7'h0, boost}, 8'h00);
    check("src uvlo", {5'h0, src}, 8'h00);
    uvlo = 1'b0; step(6);
    check("boost on", {7'h0, boost}, 8'h01);
    check("src on", {5'h0, src}, 8'h07);
  endtask : t_enable_uvlo

  task automatic t_faults();
    below_short = 3'h2; step(SHORT_T + 6); below_short = 3'h0;
    check("fault in ramp", {5'h0, fault}, 8'h00);
    wait_ramp();
    below_short = 3'h1; step(SHORT_T - 3); below_short = 3'h0; step(6);
    check("short glitch", {5'h0, fault}, 8'h00);
    below_short = 3'h2; step(SHORT_T + 5); below_short = 3'h0; step(20);
    check("short fault", {5'h0, fault}, 8'h02);
    check("short src", {5'h0, src}, 8'h05);
    below_open = 3'h1; step(OPEN_T + 8);
    check("open no rail", {5'h0, fault}, 8'h02);
    open_chk = 1'b1; step(OPEN_T + 5);
    check("open fault", {5'h0, fault}, 8'h03);
    below_open = 3'h0; open_chk = 1'b0; coil_lim = 1'b1; step(6);
    check("coil charge", {7'h0, coil}, 8'h00);
    open_chk = 1'b1; below_open = 3'h4; step(OPEN_T + 8);
    check("open blocked", {5'h0, fault}, 8'h03);
    below_open = 3'h0; open_chk = 1'b0; coil_lim = 1'b0;
    level_req = 1'b0; step(REARM_T + 10);
    check("fault clear", {5'h0, fault}, 8'h00);
    check("src off", {5'h0, src}, 8'h00);
  endtask : t_faults

  task automatic t_tie();
    int ones;
    tied = 3'h4; level_req = 1'b1; step(8); tied = 3'h0;
    check("tie fault", {5'h0, fault}, 8'h04);
    check("tie src", {5'h0, src}, 8'h03);
    level_req = 1'b0; step(REARM_T + 10);
    pwm_mode = 1'b1; step(20);
    ones = 0;
    for (int i = 0; i < 100; i++)
    begin
      step(1);
      if (src === 3'h7)
        ones++;
    end
    check("pwm duty", ones[7:0], 8'h0a);
    wait_ramp();
    pwm_mode = 1'b0; level_req = 1'b1; step(10);
  endtask : t_tie

  task automatic t_protect();
    clamp = 1'b1; step(OV_T - 20);
    check("clamp early", {7'h0, boost}, 8'h01);
    step(30); clamp = 1'b0;
    check("ov stop", {7'h0, boost}, 8'h00);
    check("ov src", {5'h0, src}, 8'h00);
    level_req = 1'b0; step(REARM_T / 2); level_req = 1'b1; step(10);
    check("short rearm", {7'h0, boost}, 8'h00);
    level_req = 1'b0; step(REARM_T + 10); level_req = 1'b1; step(6);
    check("rearmed", {7'h0, boost}, 8'h01);
    ot_hi = 1'b1; ot_lo = 1'b0; step(6);
    check("ot stop", {7'h0, boost}, 8'h00);
    ot_hi = 1'b0; step(10);
    check("ot hyst", {7'h0, boost}, 8'h00);
    ot_lo = 1'b1; step(6);
    check("ot resume", {7'h0, boost}, 8'h01);
  endtask : t_protect

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    step(16);
    rst_b = 1'b1;
    step(4);
    t_enable_uvlo();
    t_faults();
    t_tie();
    t_protect();
    complete_run();
  end

  // The whole run needs about 6200 cycles; this leaves wide margin.
  initial
  begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
endmodule : lsfs_supervisor_bench
